// [fess_pkg.sv]
// Package of the flash erase/suspend host controller: register map, status fields,
// software opcodes, flash command codes and bus-cycle timing.
// Assumes a 250 MHz system clock; all counts are derived from it.
package fess_pkg;

  localparam int CLK_PERIOD_PS = 4000;

  // Flash strobe timing in ns; least times round up to whole cycles.
  localparam int T_SETUP_NS = 20;
  localparam int T_PULSE_NS = 70;
  localparam int T_HOLD_NS = 30;
  localparam int T_RESET_NS = 500;
  localparam int SYNC_STAGES = 2;
  localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] PULSE_CYC = 8'((T_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int RESET_CYC = (T_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Suspend latencies and the sector-load window, in us.
  localparam int T_PSUSP_US = 15;
  localparam int T_ESUSP_US = 20;
  localparam int T_WINDOW_US = 50;
  localparam int PSUSP_CYC = (T_PSUSP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ESUSP_CYC = (T_ESUSP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WINDOW_CYC = (T_WINDOW_US * 1000000) / CLK_PERIOD_PS;
  localparam int WINDOW_GUARD = 64;

  // Register byte offsets.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;

  // Status bit positions.
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_LATE = 3;
  localparam int ST_ABORTED = 4;
  localparam int ST_WIN_OPEN = 5;
  localparam int ST_READY = 6;
  localparam int ST_CHIP_ER = 7;
  localparam int ST_SECT_ER = 8;
  localparam int ST_ER_SUSP = 9;
  localparam int ST_PG_SUSP = 10;
  localparam int ST_ID_MODE = 11;

  // Software opcodes written to the command register.
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_CHIP_ERASE = 4'h1;
  localparam logic [3:0] OP_SECT_ERASE = 4'h2;
  localparam logic [3:0] OP_SECT_ADD = 4'h3;
  localparam logic [3:0] OP_ER_SUSPEND = 4'h4;
  localparam logic [3:0] OP_ER_RESUME = 4'h5;
  localparam logic [3:0] OP_PG_SUSPEND = 4'h6;
  localparam logic [3:0] OP_PG_RESUME = 4'h7;
  localparam logic [3:0] OP_ID_ENTER = 4'h8;
  localparam logic [3:0] OP_ID_EXIT = 4'h9;
  localparam logic [3:0] OP_READ = 4'hA;
  localparam logic [3:0] OP_WRITE = 4'hB;
  localparam logic [3:0] OP_POLL = 4'hC;
  localparam logic [3:0] OP_HW_RESET = 4'hD;

  // Flash command codes and unlock cycles.
  localparam logic [21:0] UNLOCK1_ADDR = 22'h000555;
  localparam logic [21:0] UNLOCK2_ADDR = 22'h0002AA;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] CODE_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CODE_CHIP_ERASE = 16'h0010;
  localparam logic [15:0] CODE_SECT_ERASE = 16'h0030;
  localparam logic [15:0] CODE_ER_SUSPEND = 16'h00B0;
  localparam logic [15:0] CODE_ER_RESUME = 16'h0030;
  localparam logic [15:0] CODE_PG_SUSPEND = 16'h00B0;
  localparam logic [15:0] CODE_PG_RESUME = 16'h0030;
  localparam logic [15:0] CODE_ID_ENTER = 16'h0090;
  localparam logic [15:0] CODE_RESET = 16'h00F0;

  // Bit positions inside a status read of the flash.
  localparam int DATA_POLL_POS = 7;
  localparam int TOGGLE_POS = 6;

  typedef enum logic [2:0] {S_IDLE, S_WRITE, S_WAIT, S_READ, S_POLL, S_RST, S_RWAIT} fess_st_t;
  typedef enum logic [1:0] {P_IDLE, P_SETUP, P_PULSE, P_HOLD} fess_ph_t;

  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] data;
    logic last;
  } fess_wr_t;

endpackage

// [fess_cyc_if.sv]
// Interface between the command sequencer and the flash bus-cycle engine.
// Assumes one clock; req and done are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface fess_cyc_if;
  logic req;
  logic wr;
  logic [21:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// [fess_cycle.sv]
// Flash bus-cycle engine: one write or read cycle on the parallel flash pins per request.
// Assumes the requester waits for done before the next request.
`timescale 1ns/1ps
`default_nettype none
module fess_cycle (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Sequencer side
  fess_cyc_if.eng cyc,
  // Flash pins
  output logic [21:0] flash_addr_out,
  input wire logic [15:0] flash_dq_in,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_out,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out
);

  typedef struct packed {
    fess_pkg::fess_ph_t ph;
    logic [7:0] cnt;
    logic wr;
    logic [21:0] addr;
    logic [15:0] dout;
    logic drive;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic done;
    logic [15:0] rdata;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
  } fess_cyc_st_t;

  fess_cyc_st_t q;
  fess_cyc_st_t d;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.dq_s1 = flash_dq_in;
    d.dq_s2 = q.dq_s1;
    if (q.cnt != 8'h00)
    begin
      d.cnt = q.cnt - 8'h01;
    end
    unique case (q.ph)
      fess_pkg::P_IDLE:
      begin
        if (cyc.req)
        begin
          // Address stays put from before the falling strobe edge until after the rising one.
          d.addr = cyc.addr;
          d.dout = cyc.wdata;
          d.wr = cyc.wr;
          d.drive = cyc.wr;
          d.ce_n = 1'b0;
          d.ph = fess_pkg::P_SETUP;
          d.cnt = fess_pkg::SETUP_CYC - 8'h01;
        end
      end
      fess_pkg::P_SETUP:
      begin
        if (q.cnt == 8'h00)
        begin
          d.we_n = !q.wr;
          d.oe_n = q.wr;
          d.ph = fess_pkg::P_PULSE;
          // Reads stretch the pulse so that the synchronised data has settled.
          d.cnt = q.wr ? fess_pkg::PULSE_CYC - 8'h01 : fess_pkg::PULSE_CYC + 8'(fess_pkg::SYNC_STAGES) - 8'h01;
        end
      end
      fess_pkg::P_PULSE:
      begin
        if (q.cnt == 8'h00)
        begin
          if (!q.wr)
          begin
            d.rdata = q.dq_s2;
          end
          d.we_n = 1'b1;
          d.oe_n = 1'b1;
          d.ph = fess_pkg::P_HOLD;
          d.cnt = fess_pkg::HOLD_CYC - 8'h01;
        end
      end
      fess_pkg::P_HOLD:
      begin
        if (q.cnt == 8'h00)
        begin
          d.ce_n = 1'b1;
          d.drive = 1'b0;
          d.done = 1'b1;
          d.ph = fess_pkg::P_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      q <= '{ph: fess_pkg::P_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign cyc.done = q.done;
  assign cyc.rdata = q.rdata;
  assign flash_addr_out = q.addr;
  assign flash_dq_out = q.dout;
  assign flash_dq_oe_out = q.drive;
  assign flash_ce_n_out = q.ce_n;
  assign flash_we_n_out = q.we_n;
  assign flash_oe_n_out = q.oe_n;

endmodule
`default_nettype wire

// [fess_host.sv]
// Host controller for a parallel NOR flash: software orders erase, suspend, resume,
// identification and polling through APB registers; the block drives the flash pins.
// Assumes a zero-wait APB master and a flash whose ready/busy and data pins are asynchronous.
//
// How it works
// - Erase is six writes: two unlocks, 80H, two unlocks, then 10H or 30H.
// - Hardware reset aborts chip erase; software is told to reissue it.
// - Done when data-poll bit is one and toggle bit equal on two reads.
// - Extra sector loads only start inside the 50 us window less a 64-cycle guard; late ones set the late flag.
`timescale 1ns/1ps
`default_nettype none
module fess_host #(
  parameter int WINDOW_CYCLES = fess_pkg::WINDOW_CYC,
  parameter int ESUSP_CYCLES = fess_pkg::ESUSP_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Flash pins
  output logic [21:0] flash_addr_out,
  input wire logic [15:0] flash_dq_in,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_out,
  output logic flash_ce_n_out,
  output logic flash_we_n_out,
  output logic flash_oe_n_out,
  output logic flash_reset_n_out,
  input wire logic flash_ready_busy_n_in
);

  localparam int WIN_W = $clog2(WINDOW_CYCLES + 1);
  localparam int CNT_W = 14;

  typedef struct packed {
    fess_pkg::fess_st_t st;
    logic [3:0] op;
    logic [2:0] step;
    logic [21:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [31:0] prdata;
    logic perr;
    logic prev_tog;
    logic prev_ok;
    logic done;
    logic refused;
    logic late;
    logic aborted;
    logic chip_er;
    logic sect_er;
    logic er_susp;
    logic pg_susp;
    logic id_mode;
    logic [WIN_W-1:0] win;
    logic [CNT_W-1:0] cnt;
    logic rst_n;
    logic rb_s1;
    logic rb_s2;
    logic req;
    logic cwr;
    logic [21:0] caddr;
    logic [15:0] cdata;
  } fess_host_st_t;

  fess_host_st_t q;
  fess_host_st_t d;
  fess_cyc_if cyc ();

  // Address and data of one write of a command sequence.
  function automatic fess_pkg::fess_wr_t seq_entry(input logic [3:0] op, input logic [2:0] step,
                                                   input logic [21:0] addr, input logic [15:0] wdata);
    fess_pkg::fess_wr_t e;
    e = '{addr: addr, data: wdata, last: 1'b1};
    if (op == fess_pkg::OP_CHIP_ERASE || op == fess_pkg::OP_SECT_ERASE || op == fess_pkg::OP_ID_ENTER)
    begin
      // Unlock, unlock, set-up; erase repeats the unlocks before the final code.
      unique case (step)
        3'h0, 3'h3: e = '{addr: fess_pkg::UNLOCK1_ADDR, data: fess_pkg::UNLOCK1_DATA, last: 1'b0};
        3'h1, 3'h4: e = '{addr: fess_pkg::UNLOCK2_ADDR, data: fess_pkg::UNLOCK2_DATA, last: 1'b0};
        3'h2: e = '{addr: fess_pkg::UNLOCK1_ADDR, data: (op == fess_pkg::OP_ID_ENTER) ?
                  fess_pkg::CODE_ID_ENTER : fess_pkg::CODE_ERASE_SETUP, last: op == fess_pkg::OP_ID_ENTER};
        default: e = (op == fess_pkg::OP_CHIP_ERASE) ?
                     '{addr: fess_pkg::UNLOCK1_ADDR, data: fess_pkg::CODE_CHIP_ERASE, last: 1'b1} :
                     '{addr: addr, data: fess_pkg::CODE_SECT_ERASE, last: 1'b1};
      endcase
    end
    else
    begin
      unique case (op)
        fess_pkg::OP_SECT_ADD: e.data = fess_pkg::CODE_SECT_ERASE;
        fess_pkg::OP_ER_SUSPEND: e.data = fess_pkg::CODE_ER_SUSPEND;
        fess_pkg::OP_ER_RESUME: e.data = fess_pkg::CODE_ER_RESUME;
        fess_pkg::OP_PG_SUSPEND: e.data = fess_pkg::CODE_PG_SUSPEND;
        fess_pkg::OP_PG_RESUME: e.data = fess_pkg::CODE_PG_RESUME;
        fess_pkg::OP_ID_EXIT: e.data = fess_pkg::CODE_RESET;
        default: e.data = wdata;
      endcase
    end
    return e;
  endfunction

  fess_pkg::fess_wr_t ent;
  fess_pkg::fess_wr_t first;
  fess_pkg::fess_wr_t nxt;
  logic mapped;
  logic cmd_go;
  logic legal;
  logic [3:0] cmd_op;
  logic [31:0] status;

  always_comb
  begin
    ent = seq_entry(q.op, q.step, q.addr, q.wdata);
    nxt = seq_entry(q.op, q.step + 3'h1, q.addr, q.wdata);
    cmd_op = pwdata_in[3:0];
    first = seq_entry(cmd_op, 3'h0, q.addr, q.wdata);
    mapped = paddr_in == fess_pkg::REG_CMD || paddr_in == fess_pkg::REG_ADDR || paddr_in == fess_pkg::REG_WDATA ||
             paddr_in == fess_pkg::REG_STATUS || paddr_in == fess_pkg::REG_RDATA;
    status = 32'h00000000;
    status[fess_pkg::ST_BUSY] = q.st != fess_pkg::S_IDLE;
    status[fess_pkg::ST_DONE] = q.done;
    status[fess_pkg::ST_REFUSED] = q.refused;
    status[fess_pkg::ST_LATE] = q.late;
    status[fess_pkg::ST_ABORTED] = q.aborted;
    status[fess_pkg::ST_WIN_OPEN] = q.win != '0;
    status[fess_pkg::ST_READY] = q.rb_s2;
    status[fess_pkg::ST_CHIP_ER] = q.chip_er;
    status[fess_pkg::ST_SECT_ER] = q.sect_er;
    status[fess_pkg::ST_ER_SUSP] = q.er_susp;
    status[fess_pkg::ST_PG_SUSP] = q.pg_susp;
    status[fess_pkg::ST_ID_MODE] = q.id_mode;
    unique case (cmd_op)
      fess_pkg::OP_READ, fess_pkg::OP_POLL, fess_pkg::OP_HW_RESET, fess_pkg::OP_NOP: legal = 1'b1;
      fess_pkg::OP_WRITE: legal = !q.chip_er;
      fess_pkg::OP_SECT_ADD: legal = q.sect_er && !q.er_susp && q.win > WIN_W'(fess_pkg::WINDOW_GUARD);
      fess_pkg::OP_ER_SUSPEND: legal = q.sect_er && !q.er_susp;
      fess_pkg::OP_ER_RESUME: legal = q.er_susp && !q.pg_susp;
      fess_pkg::OP_PG_SUSPEND: legal = !q.chip_er && !q.pg_susp;
      fess_pkg::OP_PG_RESUME: legal = q.pg_susp;
      fess_pkg::OP_ID_ENTER: legal = !q.chip_er && !q.er_susp && !q.id_mode;
      fess_pkg::OP_ID_EXIT: legal = q.id_mode;
      default: legal = !q.chip_er && !q.er_susp && !q.sect_er;
    endcase
    cmd_go = psel_in && penable_in && pwrite_in && paddr_in == fess_pkg::REG_CMD;

    d = q;
    d.req = 1'b0;
    d.rb_s1 = flash_ready_busy_n_in;
    d.rb_s2 = q.rb_s1;
    if (q.win != '0)
    begin
      d.win = q.win - WIN_W'(1);
    end
    if (psel_in && !penable_in)
    begin
      d.perr = !mapped;
      unique case (paddr_in)
        fess_pkg::REG_ADDR: d.prdata = {10'h000, q.addr};
        fess_pkg::REG_WDATA: d.prdata = {16'h0000, q.wdata};
        fess_pkg::REG_STATUS: d.prdata = status;
        fess_pkg::REG_RDATA: d.prdata = {16'h0000, q.rdata};
        default: d.prdata = 32'h00000000;
      endcase
    end
    if (psel_in && penable_in && pwrite_in)
    begin
      if (paddr_in == fess_pkg::REG_ADDR)
      begin
        d.addr = pwdata_in[21:0];
      end
      if (paddr_in == fess_pkg::REG_WDATA)
      begin
        d.wdata = pwdata_in[15:0];
      end
      if (paddr_in == fess_pkg::REG_STATUS)
      begin
        d.done = q.done && !pwdata_in[fess_pkg::ST_DONE];
        d.refused = q.refused && !pwdata_in[fess_pkg::ST_REFUSED];
        d.late = q.late && !pwdata_in[fess_pkg::ST_LATE];
        d.aborted = q.aborted && !pwdata_in[fess_pkg::ST_ABORTED];
      end
    end

    unique case (q.st)
      fess_pkg::S_IDLE:
      begin
        if (cmd_go && cmd_op != fess_pkg::OP_NOP)
        begin
          if (!legal)
          begin
            if (cmd_op == fess_pkg::OP_SECT_ADD && q.sect_er && !q.er_susp)
            begin
              d.late = 1'b1;
            end
            else
            begin
              d.refused = 1'b1;
            end
          end
          else
          begin
            d.op = cmd_op;
            d.step = 3'h0;
            d.cwr = 1'b1;
            d.caddr = first.addr;
            d.cdata = first.data;
            if (q.win != '0 && cmd_op != fess_pkg::OP_SECT_ADD && cmd_op != fess_pkg::OP_ER_SUSPEND &&
                cmd_op != fess_pkg::OP_READ && cmd_op != fess_pkg::OP_POLL)
            begin
              d.win = '0;
              d.sect_er = 1'b0;
            end
            unique case (cmd_op)
              fess_pkg::OP_READ, fess_pkg::OP_POLL:
              begin
                d.req = 1'b1;
                d.cwr = 1'b0;
                d.caddr = q.addr;
                d.prev_ok = 1'b0;
                d.st = (cmd_op == fess_pkg::OP_READ) ? fess_pkg::S_READ : fess_pkg::S_POLL;
              end
              fess_pkg::OP_HW_RESET:
              begin
                d.rst_n = 1'b0;
                d.cnt = CNT_W'(fess_pkg::RESET_CYC);
                d.aborted = q.aborted || q.chip_er;
                d.st = fess_pkg::S_RST;
              end
              default:
              begin
                d.req = 1'b1;
                d.st = fess_pkg::S_WRITE;
              end
            endcase
          end
        end
      end
      fess_pkg::S_WRITE:
      begin
        if (cyc.done)
        begin
          if (!ent.last)
          begin
            d.step = q.step + 3'h1;
            d.req = 1'b1;
            d.caddr = nxt.addr;
            d.cdata = nxt.data;
          end
          else
          begin
            d.st = fess_pkg::S_IDLE;
            d.done = 1'b1;
            unique case (q.op)
              fess_pkg::OP_CHIP_ERASE: d.chip_er = 1'b1;
              fess_pkg::OP_SECT_ERASE, fess_pkg::OP_SECT_ADD:
              begin
                d.sect_er = 1'b1;
                d.win = WIN_W'(WINDOW_CYCLES);
              end
              fess_pkg::OP_ER_SUSPEND:
              begin
                d.er_susp = 1'b1;
                d.win = '0;
                if (q.win == '0)
                begin
                  d.st = fess_pkg::S_WAIT;
                  d.done = 1'b0;
                  d.cnt = CNT_W'(ESUSP_CYCLES);
                end
              end
              fess_pkg::OP_ER_RESUME: d.er_susp = 1'b0;
              fess_pkg::OP_PG_SUSPEND:
              begin
                d.pg_susp = 1'b1;
                d.st = fess_pkg::S_WAIT;
                d.done = 1'b0;
                d.cnt = CNT_W'(fess_pkg::PSUSP_CYC);
              end
              fess_pkg::OP_PG_RESUME: d.pg_susp = 1'b0;
              fess_pkg::OP_ID_ENTER: d.id_mode = 1'b1;
              fess_pkg::OP_ID_EXIT: d.id_mode = 1'b0;
              default: d.done = 1'b1;
            endcase
          end
        end
      end
      fess_pkg::S_WAIT:
      begin
        d.cnt = q.cnt - CNT_W'(1);
        if (q.cnt == '0)
        begin
          d.st = fess_pkg::S_IDLE;
          d.done = 1'b1;
        end
      end
      fess_pkg::S_READ:
      begin
        if (cyc.done)
        begin
          d.rdata = cyc.rdata;
          d.st = fess_pkg::S_IDLE;
          d.done = 1'b1;
        end
      end
      fess_pkg::S_POLL:
      begin
        if (cyc.done)
        begin
          d.rdata = cyc.rdata;
          d.prev_tog = cyc.rdata[fess_pkg::TOGGLE_POS];
          d.prev_ok = 1'b1;
          if (q.prev_ok && cyc.rdata[fess_pkg::DATA_POLL_POS] && cyc.rdata[fess_pkg::TOGGLE_POS] == q.prev_tog)
          begin
            d.st = fess_pkg::S_IDLE;
            d.done = 1'b1;
            if (!q.er_susp)
            begin
              d.chip_er = 1'b0;
              d.sect_er = 1'b0;
              d.win = '0;
            end
            // A finished program under erase suspend leaves the erase suspended.
          end
          else
          begin
            d.req = 1'b1;
          end
        end
      end
      fess_pkg::S_RST:
      begin
        d.cnt = q.cnt - CNT_W'(1);
        if (q.cnt == '0)
        begin
          d.rst_n = 1'b1;
          d.chip_er = 1'b0;
          d.sect_er = 1'b0;
          d.er_susp = 1'b0;
          d.pg_susp = 1'b0;
          d.id_mode = 1'b0;
          d.win = '0;
          d.st = fess_pkg::S_RWAIT;
        end
      end
      fess_pkg::S_RWAIT:
      begin
        if (q.rb_s2)
        begin
          d.st = fess_pkg::S_IDLE;
          d.done = 1'b1;
        end
      end
      default:
      begin
        d.st = fess_pkg::S_IDLE;
      end
    endcase
    if (cmd_go && q.st != fess_pkg::S_IDLE)
    begin
      d.refused = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      q <= '{st: fess_pkg::S_IDLE, rst_n: 1'b1, default: '0};
    end
    else
    begin
      q <= d;
    end
  end

  assign cyc.req = q.req;
  assign cyc.wr = q.cwr;
  assign cyc.addr = q.caddr;
  assign cyc.wdata = q.cdata;
  assign prdata_out = q.prdata;
  assign pready_out = 1'b1;
  assign pslverr_out = q.perr;
  assign flash_reset_n_out = q.rst_n;

  fess_cycle u_cycle (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .cyc(cyc.eng),
    .flash_addr_out(flash_addr_out),
    .flash_dq_in(flash_dq_in),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_out(flash_dq_oe_out),
    .flash_ce_n_out(flash_ce_n_out),
    .flash_we_n_out(flash_we_n_out),
    .flash_oe_n_out(flash_oe_n_out)
  );

endmodule
`default_nettype wire

// [fess_flash_model.sv]
// Behavioural flash: erase with a busy time, status toggling and id codes.
// Assumes one host on the pins; strobes are active low.
`timescale 1ns/1ps
`default_nettype none
module fess_flash_model #(
  parameter int BUSY = 300,
  parameter logic [15:0] MAKER = 16'h00A5,
  parameter logic [15:0] DEVC = 16'h005A
) (
  input wire logic clk_in, we_n_in, oe_n_in, reset_n_in,
  input wire logic [21:0] addr_in,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic ready_busy_n_out
);
  int busy = 0;
  logic armed = 0, tog = 0, idm = 0;
  logic [15:0] last = '0, val;
  always @(posedge we_n_in)
    if (busy == 0)
    begin
      if (dq_in == 16'h0090) idm = 1;
      if (dq_in == 16'h00F0) idm = 0;
      if (armed && dq_in[4:0] == 5'h10) busy = BUSY;
      armed = dq_in == 16'h0080 || (armed && dq_in[4:0] != 5'h10);
    end
  always @(posedge clk_in)
    if (!reset_n_in) busy <= 0;
    else if (busy > 0) busy <= busy - 1;
  always @(negedge oe_n_in) tog = tog ^ (busy != 0);
  assign val = idm ? (addr_in[2:1] == 2'b00 ? MAKER : DEVC) : {8'h00, busy == 0, tog, 6'h00};
  always @(posedge oe_n_in) last = val;
  // A released bus shows the inverse of the last value.
  assign dq_out = oe_n_in ? ~last : val;
  assign ready_busy_n_out = busy == 0;
endmodule
`default_nettype wire

// [fess_host_props.sv]
// Pin checker for the flash host controller.
// Assumes it is bound into fess_host.
`timescale 1ns/1ps
`default_nettype none
module fess_host_props (
  // Clock, reset and flash pins
  input wire logic clk_in, arst_n_in, flash_dq_oe_out, flash_ce_n_out, flash_we_n_out, flash_oe_n_out,
  input wire logic flash_reset_n_out,
  input wire logic [21:0] flash_addr_out,
  input wire logic [15:0] flash_dq_out
);
  wire logic ce = !flash_ce_n_out, we = !flash_we_n_out, oe = !flash_oe_n_out, rs = !flash_reset_n_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  addr_hold_a: assert property (ce && $past(ce) |-> $stable(flash_addr_out)) else $error("addr moved");
  data_hold_a: assert property (ce && $past(ce) && flash_dq_oe_out |-> $stable(flash_dq_out))
    else $error("data moved");
  we_gate_a: assert property (we |-> ce && !oe && flash_dq_oe_out) else $error("bad write strobe");
  oe_gate_a: assert property (oe |-> ce && !flash_dq_oe_out) else $error("bad read strobe");
  we_width_a: assert property ($rose(we) |-> ##17 we ##1 !we) else $error("write pulse width");
  ce_setup_a: assert property ($rose(we) |-> $past(ce, 5)) else $error("short setup");
  ce_hold_a: assert property ($fell(ce) |-> !$past(we, 8)) else $error("short hold");
  rst_width_a: assert property ($rose(rs) |-> rs [*8]) else $error("short reset");
  cover property ($rose(we));
  cover property ($rose(oe));
  cover property ($rose(rs));
endmodule
bind fess_host fess_host_props fess_host_props_i (.clk_in, .arst_n_in, .flash_dq_oe_out, .flash_ce_n_out,
  .flash_we_n_out, .flash_oe_n_out, .flash_reset_n_out, .flash_addr_out, .flash_dq_out);
`default_nettype wire

// [test_fess_host.sv]
// Self-checking bench of the flash host controller.
// Assumes a behavioural flash on the pins and APB access from tasks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %0t got %0h exp %0h", $time, a, e); end end
module test_fess_host;
  localparam logic [15:0] MAKER = 16'h00A5, DEVC = 16'h005A; // Arbitrary identification values.
  logic clk_in = 0, arst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, flash_ready_busy_n_in, re;
  logic pready_out, pslverr_out, flash_dq_oe_out, flash_ce_n_out, flash_we_n_out, flash_oe_n_out, flash_reset_n_out;
  logic [7:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0, prdata_out, r;
  logic [21:0] flash_addr_out, lasta;
  logic [15:0] flash_dq_out, flash_dq_in, model_dq, lastd;
  int nwr = 0, miscompares = 0, samples_checked = 0;
  always #2 clk_in = ~clk_in;
  assign flash_dq_in = flash_dq_oe_out ? flash_dq_out : model_dq;
  always @(negedge flash_we_n_out) begin nwr++; lasta = flash_addr_out; lastd = flash_dq_out; end
  fess_host #(.WINDOW_CYCLES(200), .ESUSP_CYCLES(20)) fess_host_i (.clk_in, .arst_n_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .flash_addr_out, .flash_dq_in,
    .flash_dq_out, .flash_dq_oe_out, .flash_ce_n_out, .flash_we_n_out, .flash_oe_n_out, .flash_reset_n_out,
    .flash_ready_busy_n_in);
  fess_flash_model #(.MAKER(MAKER), .DEVC(DEVC)) fess_flash_model_i (.clk_in, .addr_in(flash_addr_out),
    .dq_in(flash_dq_in), .we_n_in(flash_we_n_out), .oe_n_in(flash_oe_n_out), .reset_n_in(flash_reset_n_out),
    .dq_out(model_dq), .ready_busy_n_out(flash_ready_busy_n_in));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel_in <= 1; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
    @(posedge clk_in) penable_in <= 1;
    do begin @(posedge clk_in); n++; end while (pready_out !== 1'b1 && n < 50);
    r = prdata_out; re = pslverr_out; psel_in <= 0; penable_in <= 0;
    if (pready_out !== 1'b1) begin miscompares++; close_out; end
    @(posedge clk_in);
  endtask
  // Clears sticky status, issues one order and polls status until idle.
  task automatic op(input logic [3:0] c, input logic [21:0] a);
    int n = 0;
    apb(1, 8'h0C, 32'h1E); apb(1, 8'h04, {10'h0, a}); apb(1, 8'h00, {28'h0, c});
    do begin apb(0, 8'h0C, 0); n++; end while (r[0] !== 1'b0 && n < 3000);
    if (r[0] !== 1'b0) begin miscompares++; close_out; end
  endtask
  task automatic t_chip;
    int k = nwr;
    op(fess_pkg::OP_ER_RESUME, 0);
    `CHK(r[2], 1'b1)
    op(fess_pkg::OP_CHIP_ERASE, 0);
    `CHK({lastd, r[6], 32'(nwr - k)}, {fess_pkg::CODE_CHIP_ERASE, 1'b0, 32'd6})
    op(fess_pkg::OP_ER_SUSPEND, 0);
    `CHK({r[2], r[7], 32'(nwr - k)}, {2'b11, 32'd6})
    op(fess_pkg::OP_POLL, 0);
    `CHK({r[1], r[7], r[6]}, 3'b101)
    op(fess_pkg::OP_CHIP_ERASE, 0);
    op(fess_pkg::OP_HW_RESET, 0);
    `CHK({r[4], r[7], flash_ready_busy_n_in}, 3'b101)
    $display("chip erase test over");
  endtask
  task automatic t_sect;
    op(fess_pkg::OP_SECT_ERASE, 22'h012345);
    `CHK({lasta, lastd, r[5]}, {22'h012345, fess_pkg::CODE_SECT_ERASE, 1'b1})
    op(fess_pkg::OP_ER_SUSPEND, 0);
    `CHK(r[9:8], 2'b11)
    op(fess_pkg::OP_ER_RESUME, 0);
    `CHK({r[9:8], r[5]}, 3'b010)
    op(fess_pkg::OP_POLL, 22'h012345);
    `CHK(r[8], 1'b0)
    op(fess_pkg::OP_ID_ENTER, 0);
    op(fess_pkg::OP_READ, 0);
    apb(0, 8'h10, 0);
    `CHK({re, r[15:0]}, {1'b0, MAKER})
    op(fess_pkg::OP_READ, 22'h000002);
    apb(0, 8'h10, 0);
    `CHK(r[15:0], DEVC)
    apb(0, 8'h14, 0);
    `CHK({re, r}, {1'b1, 32'h0})
    op(fess_pkg::OP_ID_EXIT, 0);
    `CHK(r[11], 1'b0)
    $display("sector and id test over");
  endtask
  task automatic t_susp;
    op(fess_pkg::OP_SECT_ERASE, 22'h020000);
    op(fess_pkg::OP_SECT_ADD, 22'h030000);
    `CHK({lasta, r[5], r[3]}, {22'h030000, 2'b10})
    repeat (210) @(posedge clk_in);
    op(fess_pkg::OP_SECT_ADD, 0);
    `CHK({r[8], r[5], r[3]}, 3'b101)
    op(fess_pkg::OP_ER_SUSPEND, 0);
    op(fess_pkg::OP_PG_SUSPEND, 0);
    op(fess_pkg::OP_ID_ENTER, 0);
    `CHK({r[11:9], r[2]}, 4'b0111)
    op(fess_pkg::OP_PG_RESUME, 0);
    op(fess_pkg::OP_ER_RESUME, 0);
    op(fess_pkg::OP_POLL, 22'h020000);
    `CHK(r[10:8], 3'b000)
    op(fess_pkg::OP_PG_SUSPEND, 0);
    op(fess_pkg::OP_ID_ENTER, 0);
    op(fess_pkg::OP_ID_EXIT, 0);
    `CHK({r[11:10], r[2]}, 3'b010)
    op(fess_pkg::OP_PG_RESUME, 0);
    op(fess_pkg::OP_SECT_ERASE, 22'h020000);
    op(fess_pkg::OP_WRITE, 22'h040000);
    `CHK({lasta, r[8], r[5]}, {22'h040000, 2'b00})
    $display("suspend test over");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1;
    @(posedge clk_in);
    t_chip;
    t_sect;
    t_susp;
    close_out;
  end
endmodule
`default_nettype wire
